// File: rtl/ssp_pkg.sv
/*
  ssp_pkg: register indices, field positions, reset values and mode codes
  for the two-wire serial port block.
  assumes a byte-wide register port with one-cycle read latency.
*/
package ssp_pkg;
  localparam logic [7:0] ADDR_INTCTL  = 8'h0b;
  localparam logic [7:0] ADDR_PFLAG   = 8'h0c;
  localparam logic [7:0] ADDR_SBUF    = 8'h13;
  localparam logic [7:0] ADDR_SCTL    = 8'h14;
  localparam logic [7:0] ADDR_PCDIR   = 8'h87;
  localparam logic [7:0] ADDR_PEN     = 8'h8c;
  localparam logic [7:0] ADDR_SADDR   = 8'h93;
  localparam logic [7:0] ADDR_SSTAT   = 8'h94;

  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_PCDIR    = 8'hff;

  localparam int BIT_SIF   = 3;
  localparam int BIT_WRITE_COLLISION_BIT  = 7;
  localparam int BIT_OV    = 6;
  localparam int BIT_EN    = 5;
  localparam int BIT_CKR   = 4;
  localparam int BIT_STOP  = 4;
  localparam int BIT_START = 3;
  localparam int BIT_RW    = 2;
  localparam int BIT_BF    = 0;
  localparam int BIT_DA    = 5;
  localparam int BIT_SDADIR = 4;
  localparam int BIT_SCLDIR = 3;
  localparam int BIT_PEIE   = 6;
  localparam int BIT_GIE    = 7;

  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_SLV7_SE  = 4'he;
  localparam logic [3:0] MODE_SLV10_SE = 4'hf;
  localparam logic [3:0] MODE_MIDLE    = 4'hb;

  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [3:0] BITS_ACK  = 4'h8;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssp_req_t;

  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } ssp_pins_t;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACKA, S_HOLD, S_TX, S_ACKT, S_RX, S_ACKR} ssp_state_t;
endpackage

// File: rtl/ssp_i2c_core.sv
/*
  ssp_i2c_core: two-wire serial port, slave transmitter plus the flags that
  firmware-driven master and multi-master operation rely on.
  assumes: pins are open drain, outside logic resolves the wire from the
  enables; scl/sda arrive asynchronously and are sampled on mclk.
*/
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module ssp_i2c_core
  import ssp_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire ssp_pkg::ssp_req_t    req,
  output logic [7:0]                rdData,
  input  wire ssp_pkg::ssp_pins_t   pins,
  output logic                      sclOut,
  output logic                      sclOe,
  output logic                      sdaOut,
  output logic                      sdaOe,
  output logic                      irq
);
  import ssp_pkg::*;

  logic [7:0] intCtl_r, pFlag_r, sBuf_r, sCtl_r, pcDir_r, pEn_r, sAddr_r, sStat_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic       stretch_r;
  logic       sdaDrv_r;
  ssp_state_t state_r;
  logic [2:0] sclSync_r, sdaSync_r;
  logic       scl_r, sda_r;

  function automatic logic slaveMode(input logic [3:0] m);
    return (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7_SE) || (m == MODE_SLV10_SE);
  endfunction

  function automatic logic isWr(input ssp_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // three-stage sampling, accept a level when the last two agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
      scl_r     <= 1'b1;
      sda_r     <= 1'b1;
    end else begin
      sclSync_r <= {sclSync_r[1:0], pins.sclIn};
      sdaSync_r <= {sdaSync_r[1:0], pins.sdaIn};
      if (sclSync_r[2] == sclSync_r[1]) scl_r <= sclSync_r[2];
      if (sdaSync_r[2] == sdaSync_r[1]) sda_r <= sdaSync_r[2];
    end
  end

  logic sclNew, sdaNew, sclRise, sclFall, startDet, stopDet, enabled, slaveOn;
  assign sclNew   = (sclSync_r[2] == sclSync_r[1]) ? sclSync_r[2] : scl_r;
  assign sdaNew   = (sdaSync_r[2] == sdaSync_r[1]) ? sdaSync_r[2] : sda_r;
  assign sclRise  = !scl_r && sclNew;
  assign sclFall  = scl_r && !sclNew;
  assign startDet = scl_r && sclNew && sda_r && !sdaNew;
  assign stopDet  = scl_r && sclNew && !sda_r && sdaNew;
  assign enabled  = sCtl_r[BIT_EN];
  assign slaveOn  = enabled && slaveMode(sCtl_r[3:0]);

  logic bufWr, ckrSet, byteDone, addrMatch, nackEnd;
  assign bufWr     = isWr(req, ADDR_SBUF);
  assign addrMatch = (shift_r[7:1] == sAddr_r[7:1]);
  assign byteDone  = sclFall && (bitCnt_r == BITS_ACK)
                     && (state_r == S_ACKA || state_r == S_ACKT || state_r == S_ACKR);
  assign nackEnd   = (state_r == S_ACKT) && sclRise && sdaNew;
  assign ckrSet    = isWr(req, ADDR_SCTL) && req.wdata[BIT_CKR];

  // slave sequencer
  always_ff @(posedge mclk) begin
    if (!rstn || !slaveOn) begin
      state_r  <= S_IDLE;
      bitCnt_r <= 4'h0;
      sdaDrv_r <= 1'b0;
    end else if (startDet) begin
      state_r  <= S_ADDR;
      bitCnt_r <= 4'h0;
      sdaDrv_r <= 1'b0;
    end else if (stopDet) begin
      state_r  <= S_IDLE;
      sdaDrv_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_IDLE: ;
        S_ADDR, S_RX: begin
          if (sclRise) bitCnt_r <= bitCnt_r + 4'h1;
          if (sclFall && bitCnt_r == BITS_ACK) begin
            if (state_r == S_RX || addrMatch) begin
              sdaDrv_r <= 1'b1;
              state_r  <= (state_r == S_RX) ? S_ACKR : S_ACKA;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_ACKA, S_ACKR: begin
          if (sclFall) begin
            sdaDrv_r <= 1'b0;
            bitCnt_r <= 4'h0;
            state_r  <= (state_r == S_ACKA && shift_r[0]) ? S_HOLD : S_RX;
          end
        end
        S_HOLD: begin
          sdaDrv_r <= !shift_r[7];
          if (!stretch_r) state_r <= S_TX;
        end
        S_TX: begin
          if (sclRise) bitCnt_r <= bitCnt_r + 4'h1;
          if (sclFall) begin
            if (bitCnt_r == BITS_ACK) begin
              sdaDrv_r <= 1'b0;
              state_r  <= S_ACKT;
            end else begin
              // shift_r advances in this same edge, so the next bit is [6]
              sdaDrv_r <= !shift_r[6];
            end
          end
        end
        S_ACKT: begin
          if (nackEnd) begin
            state_r <= S_IDLE;
          end else if (sclFall) begin
            bitCnt_r <= 4'h0;
            state_r  <= S_HOLD;
          end
        end
      endcase
    end
  end

  // shift register: receive on rising, advance transmit on falling
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_r <= RST_ZERO;
    end else if (bufWr) begin
      shift_r <= req.wdata;
    end else if ((state_r == S_ADDR || state_r == S_RX) && sclRise && bitCnt_r <= BITS_LAST) begin
      shift_r <= {shift_r[6:0], sdaNew};
    end else if (state_r == S_TX && sclFall && bitCnt_r != BITS_ACK && bitCnt_r != 4'h0) begin
      shift_r <= {shift_r[6:0], 1'b1};
    end
  end

  // buffer register: address byte on any address match (read or write), received byte in S_RX
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sBuf_r <= RST_ZERO;
    end else if (bufWr) begin
      sBuf_r <= req.wdata;
    end else if (sclFall && bitCnt_r == BITS_ACK && (state_r == S_RX ||
                 (state_r == S_ADDR && addrMatch))) begin
      sBuf_r <= shift_r;
    end
  end

  // clock stretching: only software releases it
  always_ff @(posedge mclk) begin
    if (!rstn || !slaveOn) begin
      stretch_r <= 1'b0;
    end else if (ckrSet) begin
      stretch_r <= 1'b0;
    end else if (sclFall && ((state_r == S_ACKA && shift_r[0]) || (state_r == S_ACKT && !nackEnd))) begin
      stretch_r <= 1'b1;
    end
  end

  // control register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sCtl_r <= RST_ZERO;
    end else if (isWr(req, ADDR_SCTL)) begin
      sCtl_r <= req.wdata;
    end else if (sclFall && stretch_r == 1'b0 && state_r == S_ACKA && shift_r[0]) begin
      sCtl_r[BIT_CKR] <= 1'b0;
    end
  end

  // status register
  always_ff @(posedge mclk) begin
    if (!rstn || !enabled) begin
      sStat_r <= RST_ZERO;
    end else begin
      if (startDet) begin
        sStat_r[BIT_START] <= 1'b1;
        sStat_r[BIT_STOP]  <= 1'b0;
      end
      if (stopDet) begin
        sStat_r[BIT_STOP]  <= 1'b1;
        sStat_r[BIT_START] <= 1'b0;
      end
      if (sclFall && bitCnt_r == BITS_ACK && state_r == S_ADDR && addrMatch) begin
        sStat_r[BIT_RW] <= shift_r[0];
        sStat_r[BIT_DA] <= 1'b0;
      end
      if (nackEnd) begin
        sStat_r[BIT_RW] <= 1'b0;
        sStat_r[BIT_DA] <= 1'b0;
        sStat_r[BIT_BF] <= 1'b0;
      end
    end
  end

  // interrupt flag: hardware set beats software clear
  logic flagSet;
  assign flagSet = enabled && (startDet || stopDet || byteDone);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pFlag_r <= RST_ZERO;
    end else begin
      if (isWr(req, ADDR_PFLAG)) pFlag_r <= req.wdata;
      if (flagSet) pFlag_r[BIT_SIF] <= 1'b1;
    end
  end

  // plain software registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      intCtl_r <= RST_ZERO;
      pcDir_r  <= RST_PCDIR;
      pEn_r    <= RST_ZERO;
      sAddr_r  <= RST_ZERO;
    end else begin
      if (isWr(req, ADDR_INTCTL)) intCtl_r <= req.wdata;
      if (isWr(req, ADDR_PCDIR))  pcDir_r  <= req.wdata;
      if (isWr(req, ADDR_PEN))    pEn_r    <= req.wdata;
      if (isWr(req, ADDR_SADDR))  sAddr_r  <= req.wdata;
    end
  end

  // read port, one cycle latency, unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdData <= RST_ZERO;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_INTCTL: rdData <= intCtl_r;
        ADDR_PFLAG:  rdData <= pFlag_r;
        ADDR_SBUF:   rdData <= sBuf_r;
        ADDR_SCTL:   rdData <= sCtl_r;
        ADDR_PCDIR:  rdData <= pcDir_r;
        ADDR_PEN:    rdData <= pEn_r;
        ADDR_SADDR:  rdData <= sAddr_r;
        ADDR_SSTAT:  rdData <= sStat_r;
        default:     rdData <= RST_ZERO;
      endcase
    end else begin
      rdData <= RST_ZERO;
    end
  end

  // open-drain pins: firmware direction bits plus slave drive, always low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = enabled && (!pcDir_r[BIT_SCLDIR] || stretch_r);
  assign sdaOe  = enabled && (!pcDir_r[BIT_SDADIR] || sdaDrv_r);
  assign irq    = pFlag_r[BIT_SIF] && pEn_r[BIT_SIF] && intCtl_r[BIT_PEIE] && intCtl_r[BIT_GIE];

  a_flag_on_byte: assert property (@(posedge mclk) disable iff (!rstn)
    byteDone |=> pFlag_r[BIT_SIF]) else $error("flag missing after byte");
  a_stop_bit_set: assert property (@(posedge mclk) disable iff (!rstn)
    (stopDet && enabled) |=> sStat_r[BIT_STOP]) else $error("stop bit not set");
  a_start_bit_set: assert property (@(posedge mclk) disable iff (!rstn)
    (startDet && enabled) |=> sStat_r[BIT_START] && !sStat_r[BIT_STOP]) else $error("start bit wrong");
  a_disable_clears: assert property (@(posedge mclk) disable iff (!rstn)
    !enabled |=> !sStat_r[BIT_START] && !sStat_r[BIT_STOP]) else $error("flags kept while off");
  a_stretch_holds: assert property (@(posedge mclk) disable iff (!rstn)
    (stretch_r && !ckrSet && slaveOn) |=> stretch_r) else $error("clock released alone");
  a_stretch_drives: assert property (@(posedge mclk) disable iff (!rstn)
    stretch_r && enabled |-> sclOe && !sclOut) else $error("stretched clock not driven");
  a_nack_idle: assert property (@(posedge mclk) disable iff (!rstn)
    (nackEnd && !startDet && !stopDet && slaveOn) |=> state_r == S_IDLE && !sStat_r[BIT_RW]) else $error("nack not ending");
  a_buf_loads_shift: assert property (@(posedge mclk) disable iff (!rstn)
    bufWr |=> shift_r == $past(req.wdata)) else $error("shift not loaded");
  a_pins_low: assert property (@(posedge mclk) disable iff (!rstn)
    enabled && !pcDir_r[BIT_SDADIR] |-> sdaOe && !sdaOut) else $error("sda not low");

  c_read_match: cover property (@(posedge mclk) state_r == S_ACKA ##1 state_r == S_HOLD);
  c_nack_end:   cover property (@(posedge mclk) nackEnd);
  c_stop_seen:  cover property (@(posedge mclk) stopDet && enabled);
endmodule

// File: verification/ssp_bus_master.sv
/*
  ssp_bus_master: behavioural two-wire bus master that can read and write bytes.
  assumes the bench resolves the open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
module ssp_bus_master (
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      sclPull,
  output logic      sdaPull
);
  int stretchWaits;
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    stretchWaits = 0;
  end
  // release clock, wait out a stretching slave
  task automatic clkHigh();
    int n;
    sclPull = 1'b0;
    n = 0;
    while (sclLine !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (n >= 5000) stretchWaits++;
    #80;
  endtask
  task automatic start();
    sdaPull = 1'b1;
    #80;
    sclPull = 1'b1;
    #40;
  endtask
  task automatic stop();
    sdaPull = 1'b1;
    #40;
    clkHigh();
    sdaPull = 1'b0;
    #80;
  endtask
  // data changes only while the clock is low
  task automatic xferBit(input logic b, output logic s);
    sdaPull = ~b;
    #40;
    clkHigh();
    s = sdaLine;
    sclPull = 1'b1;
    #40;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xferBit(d[i], s);
    xferBit(1'b1, ack);
  endtask
  task automatic readByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xferBit(1'b1, s);
      d[i] = s;
    end
    xferBit(ack, s);
  endtask
endmodule

// File: verification/testbench.sv
/*
  testbench: register-level tests of the serial port with a bus master model.
  assumes open-drain wires with pull-ups, resolved here.
*/
`timescale 1ns/1ps
module testbench;
  import ssp_pkg::*;
  logic       mclk, rstn, irq, sclOut, sclOe, sdaOut, sdaOe, sclPull, sdaPull, sclW, sdaW, ack;
  logic [7:0] rdData, v;
  ssp_req_t   req;
  ssp_pins_t  pins;
  int         mismatches, samples_checked;
  logic [7:0] rstAddr [7] = '{ADDR_PFLAG, ADDR_SCTL, ADDR_PCDIR, ADDR_PEN, ADDR_SADDR,
                              ADDR_SSTAT, 8'h55};
  logic [7:0] rstVal  [7] = '{RST_ZERO, RST_ZERO, RST_PCDIR, RST_ZERO, RST_ZERO, RST_ZERO,
                              8'h00};
  assign sclW = ~((sclOe & ~sclOut) | sclPull);
  assign sdaW = ~((sdaOe & ~sdaOut) | sdaPull);
  assign pins = '{sclIn: sclW, sdaIn: sdaW};
  ssp_i2c_core u_dut (.mclk(mclk), .rstn(rstn), .req(req), .rdData(rdData), .pins(pins),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
  ssp_bus_master u_master (.sclLine(sclW), .sdaLine(sdaW), .sclPull(sclPull),
    .sdaPull(sdaPull));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic expectReg(input string what, input logic [7:0] a, input logic [7:0] mask,
                           input logic [7:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    check(what, rdData & mask, exp);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // slave output may only move while the clock is low
  always @(u_dut.sdaDrv_r) if (rstn === 1'b1 && sclW === 1'b1) check("sda moved", 8'h01, 8'h00);
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    req = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rstAddr[i]) expectReg("reset value", rstAddr[i], 8'hff, rstVal[i]);
    check("pin enables", {6'h0, sclOe, sdaOe}, 8'h00);
    $display("test reset done");
    regWrite(ADDR_SADDR, 8'h5a);
    regWrite(ADDR_PEN, 8'h08);
    regWrite(ADDR_INTCTL, 8'hc0);
    regWrite(ADDR_SCTL, 8'h36);
    u_master.start();
    cycles(10);
    expectReg("start seen", ADDR_SSTAT, 8'h18, 8'h08);
    check("irq on start", {7'h0, irq}, 8'h01);
    regWrite(ADDR_PFLAG, 8'h00);
    cycles(2);
    check("irq cleared", {7'h0, irq}, 8'h00);
    u_master.sendByte(8'h5b, ack);
    check("address ack", {7'h0, ack}, 8'h00);
    cycles(10);
    expectReg("read direction", ADDR_SSTAT, 8'h04, 8'h04);
    expectReg("buffer address", ADDR_SBUF, 8'hff, 8'h5b);
    expectReg("flag after address", ADDR_PFLAG, 8'h08, 8'h08);
    regWrite(ADDR_PFLAG, 8'h00);
    fork
      u_master.readByte(1'b0, v);
      begin
        cycles(300);
        check("clock stretched", {6'h0, sclOe, sclW}, 8'h02);
        regWrite(ADDR_SBUF, 8'ha5);
        regWrite(ADDR_SCTL, 8'h36);
      end
    join
    check("first byte", v, 8'ha5);
    cycles(10);
    expectReg("flag after byte", ADDR_PFLAG, 8'h08, 8'h08);
    regWrite(ADDR_PFLAG, 8'h00);
    fork
      u_master.readByte(1'b1, v);
      begin
        cycles(300);
        check("stretch after ack", {7'h0, sclOe}, 8'h01);
        regWrite(ADDR_SBUF, 8'h3c);
        regWrite(ADDR_SCTL, 8'h36);
      end
    join
    check("second byte", v, 8'h3c);
    cycles(10);
    expectReg("status after nak", ADDR_SSTAT, 8'h27, 8'h00);
    check("slave released", {6'h0, sclOe, sdaOe}, 8'h00);
    regWrite(ADDR_PFLAG, 8'h00);
    u_master.stop();
    cycles(10);
    expectReg("stop seen", ADDR_SSTAT, 8'h18, 8'h10);
    check("irq on stop", {7'h0, irq}, 8'h01);
    $display("test slave transmit done");
    u_master.start();
    u_master.sendByte(8'h21, ack);
    check("no ack to other address", {7'h0, ack}, 8'h01);
    u_master.stop();
    check("master never stuck", u_master.stretchWaits[7:0], 8'h00);
    $display("test other address done");
    regWrite(ADDR_PCDIR, 8'he7);
    cycles(2);
    check("master pins", {4'h0, sclOe, sdaOe, sclOut, sdaOut}, 8'h0c);
    regWrite(ADDR_PCDIR, 8'hff);
    cycles(10);
    regWrite(ADDR_SCTL, 8'h00);
    cycles(2);
    expectReg("flags after disable", ADDR_SSTAT, 8'h18, 8'h00);
    $display("test master pins done");
    wrap_up();
  end
endmodule
